// [bench/tb.sv]
// self-checking bench for the guarded-access watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic opt_stoppable = 1'b0;
  logic src_clk_run = 1'b1;
  logic cpu_halt = 1'b0;
  logic cpu_stop = 1'b0;
  logic wdt_clock_stop_bit = 1'b0;
  logic acc_wr = 1'b0;
  logic acc_rd = 1'b0;
  logic acc_sel_clear = 1'b0;
  logic acc_bit_op = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] acc_rdata;
  logic [7:0] wdt_mode;
  logic [18:0] wdt_count;
  logic [18:0] c;
  logic wdt_reset_out;
  logic wdt_stopped;
  logic tick_en = 1'b0;
  logic [1:0] tick_div = 2'h0;
  wire src_tick = tick_div[1];
  int n_mismatch = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  // one source tick every four clocks, far slower than the sync chain
  always @(negedge clk) begin
    if (tick_en) begin
      tick_div <= tick_div + 2'h1;
    end else begin
      // parked low so a restart never sees a false first tick
      tick_div <= 2'h0;
    end
  end
  wdtga_top dut_u (.clk, .rst, .opt_stoppable, .src_clk_run, .src_tick, .cpu_halt,
    .cpu_stop, .wdt_clock_stop_bit, .acc_wr, .acc_rd, .acc_sel_clear, .acc_bit_op,
    .acc_wdata, .acc_rdata, .wdt_reset_out, .wdt_count, .wdt_mode, .wdt_stopped);
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset_out is sticky, so every refusal case needs a fresh reset
  task automatic restart(input logic opt);
    rst = 1'b1;
    tick_en = 1'b0;
    cpu_halt = 1'b0;
    cpu_stop = 1'b0;
    wdt_clock_stop_bit = 1'b0;
    src_clk_run = 1'b1;
    opt_stoppable = opt;
    cyc(20);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic acc(input logic wr, input logic sel, input logic bt, input logic [7:0] d);
    acc_wr = wr;
    acc_rd = !wr;
    acc_sel_clear = sel;
    acc_bit_op = bt;
    acc_wdata = d;
    cyc(1);
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    cyc(1);
  endtask
  task automatic wait_rst(input int m);
    for (int i = 0; i < m && wdt_reset_out !== 1'b1; i++) begin
      cyc(1);
    end
    chk("reset_out", 1, 32'(wdt_reset_out));
    if (wdt_reset_out !== 1'b1) begin
      end_sim();
    end
  endtask
  initial begin
    restart(1'b0);
    chk("mode_rst", 32'h67, 32'(wdt_mode));
    acc(1'b0, 1'b1, 1'b0, 8'h00);
    chk("readback", 32'h9a, 32'(acc_rdata));
    tick_en = 1'b1;
    cyc(40);
    acc(1'b1, 1'b1, 1'b0, 8'hac);
    chk("key_clear", 1, 32'(wdt_count < 19'h2));
    chk("key_no_rst", 0, 32'(wdt_reset_out));
    acc(1'b1, 1'b0, 1'b0, 8'h60);
    chk("mode_set", 32'h60, 32'(wdt_mode));
    chk("first_ok", 0, 32'(wdt_reset_out));
    acc(1'b0, 1'b0, 1'b0, 8'h00);
    chk("mode_read", 32'h60, 32'(acc_rdata));
    chk("read_no_rst", 0, 32'(wdt_reset_out));
    acc(1'b1, 1'b0, 1'b0, 8'h60);
    chk("second_wr", 1, 32'(wdt_reset_out));
    for (int k = 0; k < 3; k++) begin
      restart(1'b0);
      acc(1'b1, k != 0, k != 2, k == 0 ? 8'h60 : (k == 1 ? 8'hac : 8'hab));
      chk("refused", 1, 32'(wdt_reset_out));
      chk("mode_kept", 32'h67, 32'(wdt_mode));
    end
    restart(1'b0);
    src_clk_run = 1'b0;
    cyc(4);
    acc(1'b1, 1'b1, 1'b0, 8'h11);
    cyc(10);
    chk("held_off", 0, 32'(wdt_reset_out));
    src_clk_run = 1'b1;
    wait_rst(10);
    restart(1'b1);
    tick_en = 1'b1;
    cyc(40);
    wdt_clock_stop_bit = 1'b1;
    cyc(8);
    chk("stopped", 1, 32'(wdt_stopped));
    c = wdt_count;
    chk("ran", 1, 32'(c != 19'h0));
    cyc(40);
    chk("frozen", 32'(c), 32'(wdt_count));
    wdt_clock_stop_bit = 1'b0;
    cyc(40);
    chk("still_stop", 1, 32'(wdt_stopped));
    chk("still_frozen", 32'(c), 32'(wdt_count));
    chk("no_rst", 0, 32'(wdt_reset_out));
    // prescale 1: one count per two ticks, so eight per 64 clocks
    for (int j = 0; j < 2; j++) begin
      restart(1'b1);
      acc(1'b1, 1'b0, 1'b0, 8'h68);
      tick_en = 1'b1;
      cyc(8);
      c = wdt_count;
      cyc(64);
      chk("rate_pre", 1, 32'(wdt_count - c >= 6 && wdt_count - c <= 9));
      cpu_halt = j == 0;
      cpu_stop = j == 1;
      cyc(8);
      c = wdt_count;
      cyc(40);
      chk("paused", 32'(c), 32'(wdt_count));
      cpu_halt = 1'b0;
      cpu_stop = 1'b0;
      cyc(64);
      chk("rate_post", 1, 32'(wdt_count - c >= 6 && wdt_count - c <= 9));
      chk("retained", 1, 32'(wdt_count > c));
    end
    restart(1'b0);
    acc(1'b1, 1'b0, 1'b0, 8'h60);
    tick_en = 1'b1;
    cpu_stop = 1'b1;
    cyc(200);
    chk("stop_runs", 1, 32'(wdt_count != 19'h0));
    chk("no_early", 0, 32'(wdt_reset_out));
    // periodic service in stop, well inside the overflow span
    for (int s = 0; s < 10; s++) begin
      cyc(1000);
      acc(1'b1, 1'b1, 1'b0, 8'hac);
      chk("serviced", 1, 32'(wdt_count < 19'h2));
    end
    chk("svc_no_rst", 0, 32'(wdt_reset_out));
    wait_rst(9000);
    end_sim();
  end
endmodule
`default_nettype wire

// [hdl/wdtga_defines.svh]
// constants for the guarded-access watchdog timer
// Functional notes
// RULE_01: one full-byte mode write after reset
// RULE_02: second mode write forces internal reset
// RULE_03: reset held until source clock runs
// RULE_04: mode register never set by bit access
// RULE_05: clock-stop latch holds after bit clears
// RULE_06: clearing clock-stop bit causes no reset
// RULE_07: wrong clear key forces internal reset
// RULE_08: bit access on clear register resets
// RULE_09: clear register reads fixed non-key constant
// RULE_10: non-stoppable option counts through STOP
// RULE_11: overflow in STOP still forces reset
// RULE_12: software services via auxiliary timer interrupt
// RULE_13: stoppable option pauses in HALT/STOP
// RULE_14: resume with the same clock selection
// RULE_15: resume from retained count, not zero
// RULE_16: software writes upper mode bits 011
// RULE_17: correct key restarts counter from zero
`ifndef WDTGA_DEFINES_SVH
`define WDTGA_DEFINES_SVH

`define WDTGA_KEY 8'hac
`define WDTGA_READBACK 8'h9a
`define WDTGA_MODE_RST 8'h67
`define WDTGA_CNT_W 19
`define WDTGA_OVF_BASE 11
`define WDTGA_OVF_SEL_MSB 2
`define WDTGA_OVF_SEL_LSB 0
`define WDTGA_PRE_SEL_MSB 4
`define WDTGA_PRE_SEL_LSB 3
`define WDTGA_PRE_W 3
`define WDTGA_UPPER_MSB 7
`define WDTGA_UPPER_LSB 5
`define WDTGA_UPPER_VAL 3'h3

`endif

// [hdl/wdtga_pkg.sv]
// types for the guarded-access watchdog timer
package wdtga_pkg;
  typedef enum logic {
    WDTGA_MODE_OPEN,
    WDTGA_MODE_LOCKED
  } wdtga_mode_state_t;
endpackage

// [hdl/wdtga_sync.sv]
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module wdtga_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// [hdl/wdtga_top.sv]
// guarded-access watchdog timer core
`timescale 1ns/1ps
`default_nettype none
`include "wdtga_defines.svh"
module wdtga_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic opt_stoppable,
  input wire logic src_clk_run,
  input wire logic src_tick,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  input wire logic wdt_clock_stop_bit,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic acc_sel_clear,
  input wire logic acc_bit_op,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  output logic wdt_reset_out,
  output logic [`WDTGA_CNT_W-1:0] wdt_count,
  output logic [7:0] wdt_mode,
  output logic wdt_stopped
);
  import wdtga_pkg::*;

  // overflow bit chosen by the mode register
  function automatic logic ovf_hit(input logic [`WDTGA_CNT_W-1:0] cnt,
                                   input logic [2:0] sel);
    logic [4:0] idx;
    idx = 5'(`WDTGA_OVF_BASE) + {2'h0, sel};
    return cnt[idx];
  endfunction

  // prescaler match: advance once per 2^sel source ticks
  function automatic logic pre_hit(input logic [`WDTGA_PRE_W-1:0] pre,
                                   input logic [1:0] sel);
    logic [`WDTGA_PRE_W-1:0] mask;
    mask = 3'((4'h1 << sel) - 4'h1);
    return (pre & mask) == 3'h0;
  endfunction

  logic src_run_s;
  logic tick_s;

  // source clock status and ticks arrive from another domain
  wdtga_sync u_sync_run (
    .clk(clk),
    .rst(rst),
    .async_in(src_clk_run),
    .sync_out(src_run_s)
  );

  wdtga_sync u_sync_tick (
    .clk(clk),
    .rst(rst),
    .async_in(src_tick),
    .sync_out(tick_s)
  );

  wdtga_mode_state_t mstate_reg;
  wdtga_mode_state_t mstate_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic opt_reg;
  logic opt_next;
  logic opt_done_reg;
  logic opt_done_next;
  logic stopped_reg;
  logic stopped_next;
  logic pending_reg;
  logic pending_next;
  logic wdt_reset_reg;
  logic wdt_reset_next;
  logic tick_d_reg;
  logic tick_d_next;
  logic [`WDTGA_PRE_W-1:0] pre_reg;
  logic [`WDTGA_PRE_W-1:0] pre_next;
  logic [`WDTGA_CNT_W-1:0] cnt_reg;
  logic [`WDTGA_CNT_W-1:0] cnt_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic stoppable;
  logic halted;
  logic run;
  logic tick_edge;
  logic adv;
  logic ovf;
  logic wr_mode_byte;
  logic wr_mode_bit;
  logic wr_clr_byte;
  logic wr_clr_bit;
  logic key_ok;
  logic misuse;
  logic fire;

  always_comb begin
    // before the option is caught, behave as non-stoppable: the safe side
    stoppable = opt_done_reg & opt_reg;
    halted = ~src_run_s | stopped_reg;
    run = src_run_s & ~stopped_reg & ~wdt_reset_reg
          & ~(stoppable & (cpu_halt | cpu_stop)); // [RULE_10] [RULE_13]
    tick_edge = tick_s & ~tick_d_reg;
    adv = run & tick_edge
          & pre_hit(pre_reg, mode_reg[`WDTGA_PRE_SEL_MSB:`WDTGA_PRE_SEL_LSB]); // [RULE_14]
    ovf = ovf_hit(cnt_reg, mode_reg[`WDTGA_OVF_SEL_MSB:`WDTGA_OVF_SEL_LSB]);
    wr_mode_byte = acc_wr & ~acc_sel_clear & ~acc_bit_op;
    wr_mode_bit = acc_wr & ~acc_sel_clear & acc_bit_op;
    wr_clr_byte = acc_wr & acc_sel_clear & ~acc_bit_op;
    wr_clr_bit = acc_wr & acc_sel_clear & acc_bit_op;
    key_ok = wr_clr_byte & (acc_wdata == `WDTGA_KEY);
    misuse = (wr_mode_byte & (mstate_reg == WDTGA_MODE_LOCKED)) // [RULE_02]
             | wr_mode_bit // [RULE_04]
             | (wr_clr_byte & ~key_ok) // [RULE_07]
             | wr_clr_bit; // [RULE_08]
    // the overflow is gated only by halted, not by cpu_halt or cpu_stop, so it fires in STOP too
    fire = (misuse | pending_reg | ovf) & ~halted; // [RULE_03] [RULE_11]
  end

  always_comb begin
    opt_next = opt_reg;
    opt_done_next = 1'b1;
    if (!opt_done_reg) begin
      opt_next = opt_stoppable;
    end
    mstate_next = mstate_reg;
    mode_next = mode_reg;
    if (wr_mode_byte && mstate_reg == WDTGA_MODE_OPEN) begin
      // upper bits are the caller's duty; both options ignore them
      mode_next = acc_wdata; // [RULE_01] [RULE_16]
      mstate_next = WDTGA_MODE_LOCKED; // [RULE_01]
    end
    // latch never clears, so dropping the bit neither restarts nor resets
    stopped_next = stopped_reg | (stoppable & wdt_clock_stop_bit); // [RULE_05] [RULE_06]
    // a misuse while halted waits here until the source clock runs with the stop latch clear
    pending_next = (pending_reg | misuse) & ~fire; // [RULE_03]
    wdt_reset_next = wdt_reset_reg | fire; // [RULE_02] [RULE_07] [RULE_08]
    tick_d_next = tick_s;
    pre_next = pre_reg;
    if (run && tick_edge) begin
      pre_next = pre_reg + 3'h1;
    end
    cnt_next = cnt_reg; // [RULE_15]
    if (key_ok && !wdt_reset_reg) begin
      cnt_next = '0; // [RULE_17]
      pre_next = '0;
    end else if (adv) begin
      cnt_next = cnt_reg + 19'h00001; // [RULE_10]
    end
    rdata_next = rdata_reg;
    if (acc_rd) begin
      rdata_next = acc_sel_clear ? `WDTGA_READBACK : mode_reg; // [RULE_09]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_reg <= 1'b0;
      opt_done_reg <= 1'b0;
      mstate_reg <= WDTGA_MODE_OPEN;
      mode_reg <= `WDTGA_MODE_RST;
      stopped_reg <= 1'b0;
      pending_reg <= 1'b0;
      wdt_reset_reg <= 1'b0;
      tick_d_reg <= 1'b0;
      pre_reg <= '0;
      cnt_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      opt_reg <= opt_next;
      opt_done_reg <= opt_done_next;
      mstate_reg <= mstate_next;
      mode_reg <= mode_next;
      stopped_reg <= stopped_next;
      pending_reg <= pending_next;
      wdt_reset_reg <= wdt_reset_next;
      tick_d_reg <= tick_d_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  assign acc_rdata = rdata_reg;
  assign wdt_reset_out = wdt_reset_reg;
  assign wdt_count = cnt_reg;
  assign wdt_mode = mode_reg;
  assign wdt_stopped = stopped_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_FIRST_WRITE: assert property ( // [RULE_01]
    (mstate_reg == WDTGA_MODE_OPEN && wr_mode_byte)
      |=> (mode_reg == $past(acc_wdata) && mstate_reg == WDTGA_MODE_LOCKED))
    else $error("first mode write not taken");

  AST_SECOND_WRITE: assert property ( // [RULE_02]
    (mstate_reg == WDTGA_MODE_LOCKED && wr_mode_byte && !halted)
      |=> (wdt_reset_reg && $stable(mode_reg)))
    else $error("second mode write did not reset");

  AST_HOLD_OFF: assert property ( // [RULE_03]
    (misuse && halted && !wdt_reset_reg) |=> (!wdt_reset_reg && pending_reg))
    else $error("reset not held off while source halted");

  AST_RELEASE: assert property ( // [RULE_03]
    (pending_reg && !halted) |=> wdt_reset_reg)
    else $error("held reset not released when source runs");

  AST_MODE_BITOP: assert property ( // [RULE_04]
    (wr_mode_bit && !halted) |=> ($stable(mode_reg) && wdt_reset_reg))
    else $error("bit access changed mode or no reset");

  AST_STOP_LATCH: assert property ( // [RULE_05]
    (stoppable && wdt_clock_stop_bit) |=> stopped_reg [*8])
    else $error("clock stop latch released");

  AST_NO_STOP_RESET: assert property ( // [RULE_06]
    (stopped_reg && !pending_reg && !misuse && !wdt_reset_reg)
      |=> !wdt_reset_reg)
    else $error("clearing stop bit produced reset");

  AST_BAD_KEY: assert property ( // [RULE_07]
    (wr_clr_byte && acc_wdata != `WDTGA_KEY && !halted) |=> wdt_reset_reg)
    else $error("wrong key did not reset");

  AST_CLEAR_BITOP: assert property ( // [RULE_08]
    (wr_clr_bit && !halted) |=> wdt_reset_reg)
    else $error("bit access on clear register did not reset");

  AST_READBACK: assert property ( // [RULE_09]
    (acc_rd && acc_sel_clear) |=> (acc_rdata == `WDTGA_READBACK))
    else $error("clear register readback wrong");

  AST_NONSTOP_COUNT: assert property ( // [RULE_10]
    (!stoppable && cpu_stop && adv && !key_ok) |=> (cnt_reg == $past(cnt_reg) + 19'h00001))
    else $error("non-stoppable counter paused in stop");

  AST_STOP_OVF: assert property ( // [RULE_11]
    (!stoppable && cpu_stop && ovf && src_run_s && !stopped_reg) |=> wdt_reset_reg)
    else $error("overflow in stop did not reset");

  AST_PAUSE: assert property ( // [RULE_13]
    (stoppable && (cpu_halt || cpu_stop) && !key_ok) |=> $stable(cnt_reg))
    else $error("counter moved during halt or stop");

  AST_MODE_KEEP: assert property ( // [RULE_14]
    (stoppable && (cpu_halt || cpu_stop) && !wr_mode_byte) |=> $stable(mode_reg))
    else $error("clock selection changed across standby");

  AST_RETAIN: assert property ( // [RULE_15]
    (stoppable && $fell(cpu_halt || cpu_stop) && !key_ok && !adv)
      |=> (cnt_reg == $past(cnt_reg, 2)))
    else $error("count not retained on resume");

  AST_KEY: assert property ( // [RULE_17]
    (key_ok && !wdt_reset_reg && !pending_reg && !ovf)
      |=> (cnt_reg == '0 && !wdt_reset_reg))
    else $error("correct key did not restart counter");

  AST_FIRST_NO_RESET: assert property ( // [RULE_01]
    (mstate_reg == WDTGA_MODE_OPEN && wr_mode_byte && !halted && !pending_reg && !ovf
      && !wdt_reset_reg) |=> !wdt_reset_reg)
    else $error("first mode write caused reset");

  AST_MODE_READ: assert property ( // [RULE_01]
    (acc_rd && !acc_sel_clear) |=> (acc_rdata == $past(mode_reg)))
    else $error("mode register readback wrong");

  AST_READ_NO_RESET: assert property ( // [RULE_09]
    (acc_rd && !acc_wr && !halted && !pending_reg && !ovf && !wdt_reset_reg)
      |=> !wdt_reset_reg)
    else $error("read access caused reset");

  AST_PENDING_HELD: assert property ( // [RULE_03]
    (pending_reg && halted) |=> (pending_reg && !wdt_reset_reg))
    else $error("held reset lost or fired while source halted");

  AST_STOPPED_FROZEN: assert property ( // [RULE_05]
    (stopped_reg && !key_ok) |=> $stable(cnt_reg))
    else $error("counter moved while clock stop latched");

  AST_NONSTOP_NO_LATCH: assert property ( // [RULE_10]
    (opt_done_reg && !stoppable) |=> !stopped_reg)
    else $error("non-stoppable watchdog was stopped");

  AST_OVF_RESET: assert property ( // [RULE_11]
    (ovf && !halted && !wdt_reset_reg) |=> wdt_reset_reg)
    else $error("overflow did not reset");

  // once reset is requested a late key must not revive the count
  AST_RESET_FREEZE: assert property ( // [RULE_17]
    wdt_reset_reg |=> ($stable(cnt_reg) && wdt_reset_reg))
    else $error("count moved or reset dropped after reset request");
endmodule
`default_nettype wire
